// *** rtl/iopp_ctrl.v ***
// Notes on behaviour
// R01 - path control starts only on the universal io command operator
// R02 - once started, runs alone until the device operation terminates
// R03 - on termination with notify requested, pulse external interrupt
// R04 - each decoded operator emits its 12-bit entry vector to micro-module
// R05 - condition signals always presented at micro-module address inputs
// R06 - operator picks function; internal conditions pick subroutines
// R07 - after controller start, data passes through, memory transfers stay controlled
// R08 - peripheral controller starts its device only when told, then runs alone
// R09 - peripheral controller uses link only for data and result status; code also takes resume requests from it on link_resume_req
// R10 - eight link ports with priority arbitration among active ones
// R11 - only this block opens a communication with a peripheral controller
// R12 - communication suspends while controller works; either side may resume
// R13 - instructions arrive over shared path; memory reached through controllers
// R14 - micro-module delivers control, data and addresses over its interface
// R15 - words sent on 52-bit write bus, received on 52-bit read bus
// R16 - 19-bit one-way input carries tag and high 16 bits of C
// R17 - stack busses shared; one user at a time
// R18 - transfer and memory controllers join stack busses to memory busses
// R19 - controller and family status signals routed into this logic
// R20 - decode family C and K variant operators and start micro-code
// R21 - entry vector 12 bits on the bus that returns sequence counts
// R22 - track returned sequence address for error interrupt parameters
`timescale 1ns/1ps
`include "iopp_defines.vh"
`default_nettype none
module iopp_ctrl (
	// clock and reset
	input  wire        clk,
	input  wire        rstn,
	// data processor operator interface
	input  wire        op_valid,
	input  wire        fam_c,
	input  wire        fam_k,
	input  wire        variant,
	input  wire [15:0] op_code,
	input  wire        notify_req,
	// controller status inputs
	input  wire [7:0]  ctl_status,
	// micro-module interface
	input  wire [7:0]  ctl_field_a,
	input  wire [4:0]  ctl_field_b,
	input  wire [11:0] seq_addr_in,
	output wire [11:0] entry_vec,
	output wire        entry_vec_oe,
	output wire [15:0] cond_sig,
	input  wire        uc_done,
	input  wire        uc_error,
	// stack busses
	output wire [51:0] stack_write_bus,
	output wire        stack_write_req,
	input  wire        stack_write_gnt,
	input  wire [51:0] stack_read_bus,
	input  wire        stack_read_gnt,
	input  wire [18:0] creg_tag_hi,
	// memory transfer request
	output wire        mem_req,
	input  wire        mem_ack,
	// message link ports
	output wire [7:0]  link_open,
	input  wire [7:0]  link_resume_req,
	input  wire [7:0]  link_result,
	input  wire [51:0] link_data_in,
	output wire [2:0]  link_sel,
	// interrupt controller
	output wire        ext_irq,
	output wire [11:0] err_seq_addr,
	output wire        err_irq
);
	localparam ST_IDLE = 2'h0;
	localparam ST_RUN  = 2'h1;
	localparam ST_SUSP = 2'h2;
	localparam ST_XFER = 2'h3;

	reg  [1:0]  state_ff,   nxt_state;
	reg  [11:0] ev_ff,      nxt_ev;
	reg         ev_oe_ff,   nxt_ev_oe;
	reg         io_fn_ff,   nxt_io_fn;
	reg         notify_ff,  nxt_notify;
	reg         irq_ff,     nxt_irq;
	reg  [11:0] seq_ff;
	reg  [11:0] err_ff;
	reg         err_irq_ff;
	reg  [7:0]  open_ff,    nxt_open;
	reg  [2:0]  port_ff,    nxt_port;
	reg  [51:0] wr_ff,      nxt_wr;
	reg         wr_req_ff,  nxt_wr_req;
	reg  [51:0] rd_ff;
	reg  [18:0] creg_ff;
	reg  [7:0]  res_s1_ff,  res_s2_ff;
	reg  [7:0]  rsm_s1_ff,  rsm_s2_ff;
	reg  [51:0] ldat_s1_ff, ldat_s2_ff;
	wire        arb_valid;
	wire [2:0]  arb_idx;
	reg  [11:0] dec_ev;
	reg         dec_hit;

	// operator decode to entry vector
	function [12:0] iopp_decode;
		input        fc;
		input        fk;
		input [15:0] code;
		begin
			iopp_decode = 13'h0;
			if (fc && code == `IOPP_OP_RD_TIME) begin
				iopp_decode = {1'b1, `IOPP_EV_RD_TIME};
			end else if (fk && code == `IOPP_OP_RD_COUNT) begin
				iopp_decode = {1'b1, `IOPP_EV_RD_COUNT};
			end else if (fk && code == `IOPP_OP_SET_RUN) begin
				iopp_decode = {1'b1, `IOPP_EV_SET_RUN};
			end else if (fk && code == `IOPP_OP_WR_TIME) begin
				iopp_decode = {1'b1, `IOPP_EV_WR_TIME};
			end else if (fk && code == `IOPP_OP_IO_CMD) begin
				iopp_decode = {1'b1, `IOPP_EV_IO_CMD};
			end
		end
	endfunction

	// R20 variant operator decode
	always @* begin
		{dec_hit, dec_ev} = iopp_decode(fam_c, fam_k, op_code);
		dec_hit = dec_hit & variant & op_valid;
	end

	// R10 link port arbitration
	iopp_link_arb u_arb (
		.clk       (clk),
		.rstn      (rstn),
		.req       ((rsm_s2_ff | res_s2_ff) & open_ff),
		.advance   (state_ff == ST_SUSP),
		.gnt_valid (arb_valid),
		.gnt_idx   (arb_idx)
	);

	// main sequencing
	always @* begin
		nxt_state  = state_ff;
		nxt_ev     = ev_ff;
		nxt_ev_oe  = 1'b0;
		nxt_io_fn  = io_fn_ff;
		nxt_notify = notify_ff;
		nxt_irq    = 1'b0;
		nxt_open   = open_ff;
		nxt_port   = port_ff;
		nxt_wr     = wr_ff;
		nxt_wr_req = wr_req_ff;
		case (state_ff)
			ST_IDLE: begin
				// R04 issue entry vector
				if (dec_hit) begin
					nxt_ev     = dec_ev;
					nxt_ev_oe  = 1'b1;
					nxt_state  = ST_RUN;
					// R01 io path only on command op
					nxt_io_fn  = (dec_ev == `IOPP_EV_IO_CMD);
					nxt_notify = notify_req;
				end
			end
			ST_RUN: begin
				// R11 open link to chosen port
				if (io_fn_ff && ctl_field_b[0]) begin
					nxt_port                = ctl_field_a[2:0];
					nxt_open[ctl_field_a[2:0]] = 1'b1;
				end
				// R15 stack write request
				if (ctl_field_b[1] && !wr_req_ff) begin
					nxt_wr     = rd_ff;
					nxt_wr_req = 1'b1;
				end
				if (io_fn_ff && ctl_field_b[2]) begin
					nxt_state = ST_SUSP;
				end else if (uc_done && !io_fn_ff) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_SUSP: begin
				// R12 resume on peripheral or micro-code
				if (arb_valid) begin
					nxt_port  = arb_idx;
					nxt_state = ST_XFER;
				end else if (ctl_field_b[3]) begin
					nxt_state = ST_XFER;
				end
			end
			ST_XFER: begin
				// R07 pass link data to stack
				if (!wr_req_ff) begin
					nxt_wr     = ldat_s2_ff;
					nxt_wr_req = 1'b1;
				end
				// R02 finish on result status
				if (res_s2_ff[port_ff]) begin
					nxt_open[port_ff] = 1'b0;
					nxt_state         = ST_IDLE;
					nxt_io_fn         = 1'b0;
					// R03 notify interrupt
					nxt_irq           = notify_ff;
				end else if (mem_ack) begin
					nxt_state = ST_SUSP;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
		// R17 release write bus once granted
		if (wr_req_ff && stack_write_gnt) begin
			nxt_wr_req = 1'b0;
		end
	end

	// state registers
	always @(posedge clk) begin
		if (!rstn) begin
			state_ff  <= ST_IDLE;
			ev_ff     <= 12'h000;
			ev_oe_ff  <= 1'b0;
			io_fn_ff  <= 1'b0;
			notify_ff <= 1'b0;
			irq_ff    <= 1'b0;
			open_ff   <= 8'h00;
			port_ff   <= 3'h0;
			wr_ff     <= `IOPP_STAT_RST;
			wr_req_ff <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			ev_ff     <= nxt_ev;
			ev_oe_ff  <= nxt_ev_oe;
			io_fn_ff  <= nxt_io_fn;
			notify_ff <= nxt_notify;
			irq_ff    <= nxt_irq;
			open_ff   <= nxt_open;
			port_ff   <= nxt_port;
			wr_ff     <= nxt_wr;
			wr_req_ff <= nxt_wr_req;
		end
	end

	// R22 sequence tracking and error capture
	always @(posedge clk) begin
		if (!rstn) begin
			seq_ff     <= 12'h000;
			err_ff     <= 12'h000;
			err_irq_ff <= 1'b0;
		end else begin
			if (!ev_oe_ff) begin
				seq_ff <= seq_addr_in;
			end
			err_irq_ff <= uc_error;
			if (uc_error) begin
				err_ff <= seq_ff;
			end
		end
	end

	// R16 capture stack data and C register field
	always @(posedge clk) begin
		if (!rstn) begin
			rd_ff   <= 52'h0;
			creg_ff <= 19'h0;
		end else begin
			if (stack_read_gnt) begin
				rd_ff <= stack_read_bus;
			end
			creg_ff <= creg_tag_hi;
		end
	end

	// link input synchronisers
	always @(posedge clk) begin
		if (!rstn) begin
			res_s1_ff  <= 8'h00;
			res_s2_ff  <= 8'h00;
			rsm_s1_ff  <= 8'h00;
			rsm_s2_ff  <= 8'h00;
			ldat_s1_ff <= 52'h0;
			ldat_s2_ff <= 52'h0;
		end else begin
			res_s1_ff  <= link_result;
			res_s2_ff  <= res_s1_ff;
			rsm_s1_ff  <= link_resume_req;
			rsm_s2_ff  <= rsm_s1_ff;
			ldat_s1_ff <= link_data_in;
			ldat_s2_ff <= ldat_s1_ff;
		end
	end

	// R05 condition levels, R06 internal state steers subroutines
	assign cond_sig        = {ctl_status[3:0], creg_ff[18:16], arb_valid,
	                          io_fn_ff, notify_ff, state_ff, open_ff[3:0]};
	// R21 shared vector bus drive
	assign entry_vec       = ev_ff;
	assign entry_vec_oe    = ev_oe_ff;
	assign stack_write_bus = wr_ff;
	assign stack_write_req = wr_req_ff;
	// R13 memory access through controllers
	assign mem_req         = (state_ff == ST_XFER) && !res_s2_ff[port_ff];
	assign link_open       = open_ff;
	assign link_sel        = port_ff;
	assign ext_irq         = irq_ff;
	assign err_seq_addr    = err_ff;
	assign err_irq         = err_irq_ff;
endmodule
`default_nettype wire

// *** rtl/iopp_defines.vh ***
`ifndef IOPP_DEFINES_VH
`define IOPP_DEFINES_VH
// operator codes
`define IOPP_OP_RD_TIME    16'h95A7
`define IOPP_OP_RD_COUNT   16'h9540
`define IOPP_OP_SET_RUN    16'h9541
`define IOPP_OP_WR_TIME    16'h9549
`define IOPP_OP_IO_CMD     16'h954C
// entry vectors, 12 bits
`define IOPP_EV_RD_TIME    12'h010
`define IOPP_EV_RD_COUNT   12'h020
`define IOPP_EV_SET_RUN    12'h030
`define IOPP_EV_WR_TIME    12'h040
`define IOPP_EV_IO_CMD     12'h050
// widths
`define IOPP_EV_W          12
`define IOPP_WORD_W        52
`define IOPP_CREG_W        19
`define IOPP_NPORT         8
`define IOPP_PORT_W        3
// result status reset value
`define IOPP_STAT_RST      52'h0
`endif

// *** rtl/iopp_link_arb.v ***
`timescale 1ns/1ps
`default_nettype none
// round-robin grant among the message link ports
module iopp_link_arb (
	// clock and reset
	input  wire       clk,
	input  wire       rstn,
	// requests and grant
	input  wire [7:0] req,
	input  wire       advance,
	output wire       gnt_valid,
	output wire [2:0] gnt_idx
);
	reg  [2:0] last_ff;
	reg  [2:0] pick;
	reg        found;
	reg  [2:0] cand;
	integer    i;

	// search starting just after the last granted port
	always @* begin
		pick  = 3'h0;
		found = 1'b0;
		cand  = 3'h0;
		for (i = 1; i <= 8; i = i + 1) begin
			cand = last_ff + i[2:0];
			if (!found && req[cand]) begin
				pick  = cand;
				found = 1'b1;
			end
		end
	end

	assign gnt_valid = found;
	assign gnt_idx   = pick;

	// remember the winner once served
	always @(posedge clk) begin
		if (!rstn) begin
			last_ff <= 3'h7;
		end else if (advance && found) begin
			last_ff <= pick;
		end
	end
endmodule
`default_nettype wire

// *** tb/iopp_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iopp_defines.vh"
// temporal checks on the control block ports
module iopp_monitor (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        op_valid,
	input wire logic        variant,
	input wire logic [11:0] entry_vec,
	input wire logic        entry_vec_oe,
	input wire logic [4:0]  ctl_field_b,
	input wire logic        stack_write_req,
	input wire logic        stack_write_gnt,
	input wire logic [51:0] stack_write_bus,
	input wire logic        mem_req,
	input wire logic [7:0]  link_open,
	input wire logic        uc_error,
	input wire logic        ext_irq,
	input wire logic        err_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	ev_pulse_a: assert property (entry_vec_oe |=> !entry_vec_oe)
		else $error("entry strobe longer than one cycle");
	ev_code_a: assert property (entry_vec_oe |-> entry_vec inside {`IOPP_EV_RD_TIME,
		`IOPP_EV_RD_COUNT, `IOPP_EV_SET_RUN, `IOPP_EV_WR_TIME, `IOPP_EV_IO_CMD})
		else $error("entry vector outside the set");
	oe_cause_a: assert property (entry_vec_oe |-> $past(op_valid && variant))
		else $error("entry vector without operator");
	irq_cause_a: assert property (ext_irq |-> $past(link_open) != 8'h00)
		else $error("interrupt without open link");
	err_dly_a: assert property ($past(rstn) |-> err_irq == $past(uc_error))
		else $error("error flag not one cycle behind");
	xfer_open_a: assert property (mem_req |-> link_open != 8'h00)
		else $error("memory request with no open link");
	wr_hold_a: assert property (stack_write_req && !stack_write_gnt
		|=> stack_write_req && $stable(stack_write_bus))
		else $error("stack write dropped before grant");
	open_cause_a: assert property ((link_open & ~$past(link_open)) != 8'h00
		|-> $past(ctl_field_b[0]))
		else $error("link opened without request");
endmodule
bind iopp_ctrl iopp_monitor mon (.clk(clk), .rstn(rstn), .op_valid(op_valid),
	.variant(variant), .entry_vec(entry_vec), .entry_vec_oe(entry_vec_oe),
	.ctl_field_b(ctl_field_b), .stack_write_req(stack_write_req),
	.stack_write_gnt(stack_write_gnt), .stack_write_bus(stack_write_bus),
	.mem_req(mem_req), .link_open(link_open), .uc_error(uc_error),
	.ext_irq(ext_irq), .err_irq(err_irq));
`default_nettype wire

// *** tb/iopp_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iopp_defines.vh"
// micro-module and link controller stand-in
module iopp_partner (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [2:0]  port,
	input  wire logic [3:0]  dly,
	input  wire logic        entry_vec_oe,
	input  wire logic [11:0] entry_vec,
	input  wire logic [7:0]  link_open,
	input  wire logic        mem_req,
	output logic      [7:0]  ctl_field_a,
	output logic      [4:0]  ctl_field_b,
	output logic      [11:0] seq_addr_in,
	output logic             uc_done,
	output logic      [7:0]  link_resume_req,
	output logic      [7:0]  link_result,
	output logic      [51:0] link_data_in,
	output logic             mem_ack
);
	logic [3:0] st_ff;
	logic [3:0] cnt_ff;
	logic       io_ff;
	// step through one function; data lines change every cycle
	always @(posedge clk) begin
		ctl_field_b <= 5'h00;
		uc_done <= 1'b0;
		mem_ack <= 1'b0;
		cnt_ff <= cnt_ff - 4'h1;
		seq_addr_in <= rstn ? seq_addr_in + 12'h001 : 12'h000;
		link_data_in <= {4'hA, {4{seq_addr_in}}};
		if (!rstn) begin
			st_ff <= 4'h0;
			ctl_field_a <= 8'h00;
			link_resume_req <= 8'h00;
			link_result <= 8'h00;
		end else case (st_ff)
		4'h0: if (entry_vec_oe) begin
			io_ff <= entry_vec == `IOPP_EV_IO_CMD;
			cnt_ff <= dly;
			st_ff <= 4'h1;
		end
		// fields and done come from the sequencer
		4'h1: if (cnt_ff == 4'h0) begin
			uc_done <= !io_ff;
			st_ff <= io_ff ? 4'h2 : 4'h0;
		end
		4'h2, 4'h3, 4'h4: begin
			ctl_field_a <= {5'h00, port};
			ctl_field_b <= 5'h01 << (st_ff - 4'h2);
			cnt_ff <= dly;
			st_ff <= st_ff + 4'h1;
		end
		// controller runs alone, then asks to resume
		4'h5: if (cnt_ff == 4'h0) begin
			link_resume_req[port] <= 1'b1;
			st_ff <= 4'h6;
		end
		// memory side answers after the resume has settled
		4'h6: if (mem_req) begin
			link_resume_req <= 8'h00;
			cnt_ff <= 4'h5;
			st_ff <= 4'h7;
		end
		4'h7: if (cnt_ff == 4'h0) begin
			mem_ack <= 1'b1;
			st_ff <= 4'h8;
		end
		// status only on the port opened, held till closed
		default: begin
			link_result[port] <= link_open[port];
			if (!link_open[port])
				st_ff <= 4'h0;
		end
		endcase
	end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iopp_defines.vh"
module testbench;
	logic        clk, rstn, op_valid, fam_c, fam_k, variant, notify_req, uc_error;
	logic        stack_write_gnt, stack_read_gnt, entry_vec_oe, stack_write_req;
	logic        mem_req, mem_ack, uc_done, ext_irq, err_irq, n, seen, done;
	logic [2:0]  port, link_sel;
	logic [3:0]  dly;
	logic [4:0]  ctl_field_b;
	logic [7:0]  ctl_status, ctl_field_a, link_open, link_resume_req, link_result;
	logic [11:0] seq_addr_in, entry_vec, err_seq_addr;
	logic [15:0] op_code, c, cond_sig;
	logic [18:0] creg_tag_hi;
	logic [31:0] r, g;
	logic [51:0] stack_write_bus, stack_read_bus, link_data_in;
	integer      seed, n_errors, cmp_count, i, k, irqs;
	logic [15:0] ops [5] = '{`IOPP_OP_RD_TIME, `IOPP_OP_RD_COUNT, `IOPP_OP_SET_RUN,
		`IOPP_OP_WR_TIME, `IOPP_OP_IO_CMD};
	iopp_ctrl dut (.clk(clk), .rstn(rstn), .op_valid(op_valid), .fam_c(fam_c),
		.fam_k(fam_k), .variant(variant), .op_code(op_code), .notify_req(notify_req),
		.ctl_status(ctl_status), .ctl_field_a(ctl_field_a), .ctl_field_b(ctl_field_b),
		.seq_addr_in(seq_addr_in), .entry_vec(entry_vec), .entry_vec_oe(entry_vec_oe),
		.cond_sig(cond_sig), .uc_done(uc_done), .uc_error(uc_error),
		.stack_write_bus(stack_write_bus), .stack_write_req(stack_write_req),
		.stack_write_gnt(stack_write_gnt), .stack_read_bus(stack_read_bus),
		.stack_read_gnt(stack_read_gnt), .creg_tag_hi(creg_tag_hi), .mem_req(mem_req),
		.mem_ack(mem_ack), .link_open(link_open), .link_resume_req(link_resume_req),
		.link_result(link_result), .link_data_in(link_data_in), .link_sel(link_sel),
		.ext_irq(ext_irq), .err_seq_addr(err_seq_addr), .err_irq(err_irq));
	iopp_partner far (.clk(clk), .rstn(rstn), .port(port), .dly(dly),
		.entry_vec_oe(entry_vec_oe), .entry_vec(entry_vec), .link_open(link_open),
		.mem_req(mem_req), .ctl_field_a(ctl_field_a), .ctl_field_b(ctl_field_b),
		.seq_addr_in(seq_addr_in), .uc_done(uc_done), .link_resume_req(link_resume_req),
		.link_result(link_result), .link_data_in(link_data_in), .mem_ack(mem_ack));
	// clock and random stack grants
	always #5 clk = ~clk;
	always @(posedge clk) begin
		g = $random(seed);
		stack_write_gnt <= g[0];
		stack_read_gnt <= g[1];
	end
	// expected entry vector of an operator
	function automatic logic [11:0] exp_ev(input logic [15:0] code);
		case (code)
		`IOPP_OP_RD_TIME: exp_ev = `IOPP_EV_RD_TIME;
		`IOPP_OP_RD_COUNT: exp_ev = `IOPP_EV_RD_COUNT;
		`IOPP_OP_SET_RUN: exp_ev = `IOPP_EV_SET_RUN;
		`IOPP_OP_WR_TIME: exp_ev = `IOPP_EV_WR_TIME;
		default: exp_ev = `IOPP_EV_IO_CMD;
		endcase
	endfunction
	task check(input logic [51:0] seen_v, input logic [51:0] exp, input string what);
		cmp_count++;
		if (seen_v !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen_v);
		end
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one operator presented for one cycle
	task issue(input logic [15:0] code, input logic nt);
		@(posedge clk);
		op_valid <= 1'b1;
		variant <= 1'b1;
		op_code <= code;
		notify_req <= nt;
		fam_c <= code == `IOPP_OP_RD_TIME;
		fam_k <= code != `IOPP_OP_RD_TIME;
		@(posedge clk);
		op_valid <= 1'b0;
	endtask
	initial begin
		{clk, rstn, op_valid, fam_c, fam_k, variant, notify_req, uc_error} = 8'h00;
		{stack_write_gnt, stack_read_gnt, port, dly, ctl_status} = 17'h00000;
		{op_code, creg_tag_hi, stack_read_bus} = 87'h0;
		{seed, n_errors, cmp_count} = {32'h3F85, 64'h0};
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1 check({ext_irq, entry_vec_oe, link_open, stack_write_req}, 52'h0, "reset");
		check({cond_sig, link_sel, mem_req, err_seq_addr}, 52'h0, "reset outputs");
		issue(16'h9542, 1'b0);
		#1 check(entry_vec_oe, 1'b0, "undecoded");
		for (i = 0; i < 15; i++) begin
			c = ops[i % 5];
			r = $random(seed);
			@(posedge clk);
			{n, port, dly} <= r[7:0];
			{ctl_status, creg_tag_hi} <= {r[31:24], r[18:0]};
			stack_read_bus <= {r[19:0], r};
			issue(c, r[7]);
			#1 check(entry_vec_oe, 1'b1, "strobe");
			check(entry_vec, exp_ev(c), "vector");
			issue(`IOPP_OP_RD_TIME, 1'b0);
			#1 check(entry_vec_oe, 1'b0, "busy");
			{irqs, seen, done} = 0;
			for (k = 0; k < 300 && !done; k++) begin
				@(posedge clk);
				#1 irqs += ext_irq;
				seen |= link_open != 8'h00;
				done = c == `IOPP_OP_IO_CMD ? seen && link_open == 8'h00 : k == 40;
			end
			repeat (2) @(posedge clk) #1 irqs += ext_irq;
			check(done, 1'b1, "finished");
			check(irqs, n && c == `IOPP_OP_IO_CMD, "interrupts");
			check(cond_sig, {r[27:24], r[18:16], 2'h0, n, 6'h00}, "status");
			if (c == `IOPP_OP_IO_CMD) check(link_sel, port, "port");
		end
		c = {4'h0, seq_addr_in};
		@(posedge clk) uc_error <= 1'b1;
		@(posedge clk) uc_error <= 1'b0;
		#1 check(err_irq, 1'b1, "error flag");
		check(err_seq_addr, c[11:0], "error address");
		final_report;
	end
endmodule
`default_nettype wire
